// ---- frame_timer_pkg.sv ----
// constants for the host frame timer block
`default_nettype none
package frame_timer_pkg;
   localparam logic [7:0] CMD_INTERVAL_RD = 8'h0d;
   localparam logic [7:0] CMD_INTERVAL_WR = 8'h8d;
   localparam logic [7:0] CMD_REMAINING_RD = 8'h0e;
   localparam int FI_W = 14;
   localparam int BUDGET_W = 15;
   localparam int BUDGET_LSB = 16;
   localparam int TOGGLE_BIT = 31;
   localparam logic [13:0] FI_NOMINAL = 14'h2edf;
   localparam logic [31:0] INTERVAL_RESET = 32'h00002edf;
   localparam int CLK_HZ = 10_000_000;
   localparam int BIT_HZ = 12_000_000;
   localparam logic [31:0] BIT_HZ_W = 32'h00b71b00;
   localparam logic [31:0] CLK_HZ_W = 32'h00989680;
endpackage
`default_nettype wire

// ---- usb_host_frame_timer.sv ----
// frame interval register, frame remaining down counter and largest packet budget
`default_nettype none
module usb_host_frame_timer
   import frame_timer_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic [31:0] cmd_wdata,
   input wire logic controller_soft_reset,
   input wire logic operational_state,
   output logic [31:0] rdata,
   output logic rdata_valid,
   output logic frame_boundary,
   output logic bit_tick,
   output logic [BUDGET_W-1:0] packet_count
);
   // ------------------------------------------------------------
   // bit-time tick
   // ------------------------------------------------------------
   // phase accumulator: bit rate exceeds clk, so one tick per clk is the best
   // reachable; the accumulator keeps the long-run average honest when it is not
   // limitation: at this clk the tick is high on every edge, so a frame lasts
   // interval + 1 clk periods rather than interval + 1 true bit times
   logic [31:0] phase_q;
   logic [32:0] phase_sum;
   logic tick;
   logic [31:0] phase_d;
   assign phase_sum = {1'b0, phase_q} + {1'b0, BIT_HZ_W};
   assign tick = (phase_sum >= {1'b0, CLK_HZ_W});
   assign phase_d = tick ? 32'(phase_sum - {1'b0, CLK_HZ_W}) : phase_sum[31:0];

   // ------------------------------------------------------------
   // register decode
   // ------------------------------------------------------------
   logic [31:0] interval_q;
   logic [FI_W-1:0] remain_q;
   logic remain_toggle_q;
   logic oper_q;
   wire wr_interval = cmd_valid && (cmd_code == CMD_INTERVAL_WR);
   wire rd_interval = cmd_valid && (cmd_code == CMD_INTERVAL_RD);
   wire rd_remaining = cmd_valid && (cmd_code == CMD_REMAINING_RD);
   wire enter_oper = operational_state && !oper_q;
   wire at_zero = (remain_q == '0);
   wire reload = (tick && at_zero) || enter_oper;
   wire [FI_W-1:0] fi_field = interval_q[FI_W-1:0];
   // reserved bits 15..14 are dropped on write so they always read zero
   wire [31:0] interval_wmask = {cmd_wdata[31:BUDGET_LSB], 2'b00, cmd_wdata[FI_W-1:0]};
   wire [31:0] remain_view = {remain_toggle_q, 17'h00000, remain_q};
   // read selection; an idle or unknown code returns zero so the bus stays quiet
   wire [31:0] read_sel = rd_interval ? interval_q :
      (rd_remaining ? remain_view : 32'h00000000);
   logic [31:0] interval_d;
   always_comb begin
      interval_d = interval_q;
      if (wr_interval) begin
         interval_d = interval_wmask;
      end
      // soft reset wins over a write in the same cycle, only the interval field
      if (controller_soft_reset) begin
         interval_d[FI_W-1:0] = FI_NOMINAL;
      end
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   // tick and control registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_q <= '0;
         bit_tick <= 1'b0;
         oper_q <= 1'b0;
         interval_q <= INTERVAL_RESET;
      end else begin
         phase_q <= phase_d;
         bit_tick <= tick;
         oper_q <= operational_state;
         interval_q <= interval_d;
      end
   end

   // remaining counter, toggle copy and budget counter
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         remain_q <= '0;
         remain_toggle_q <= 1'b0;
         packet_count <= '0;
         frame_boundary <= 1'b0;
      end else begin
         frame_boundary <= reload;
         if (reload) begin
            remain_q <= fi_field;
            packet_count <= interval_q[BUDGET_LSB +: BUDGET_W];
         end else if (tick) begin
            remain_q <= remain_q - 1'b1;
         end
         if (tick && at_zero) begin
            remain_toggle_q <= interval_q[TOGGLE_BIT];
         end
      end
   end

   // read answer one cycle after the command
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= '0;
         rdata_valid <= 1'b0;
      end else begin
         rdata_valid <= rd_interval || rd_remaining;
         rdata <= read_sel;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   sequence s_zero_tick;
      tick && at_zero && !enter_oper;
   endsequence
   a_reset_nominal: assert property (@(posedge clk) disable iff (!arst_n)
      controller_soft_reset |=> interval_q[FI_W-1:0] == FI_NOMINAL)
      else $error("soft reset did not restore interval");
   a_count_down: assert property (@(posedge clk) disable iff (!arst_n)
      tick && !at_zero && !enter_oper |=> remain_q == $past(remain_q) - 1'b1)
      else $error("remaining did not decrement");
   a_zero_reload: assert property (@(posedge clk) disable iff (!arst_n)
      s_zero_tick |=> remain_q == $past(fi_field))
      else $error("remaining did not reload");
   a_toggle_copy: assert property (@(posedge clk) disable iff (!arst_n)
      s_zero_tick |=> remain_toggle_q == $past(interval_q[TOGGLE_BIT]))
      else $error("toggle not copied");
   a_budget_load: assert property (@(posedge clk) disable iff (!arst_n)
      reload |=> packet_count == $past(interval_q[BUDGET_LSB +: BUDGET_W]))
      else $error("budget not loaded");
   a_oper_entry: assert property (@(posedge clk) disable iff (!arst_n)
      enter_oper |=> remain_q == $past(fi_field) ##0 frame_boundary)
      else $error("no reload on operational entry");
   // the boundary pulse follows every reload and nothing else
   a_boundary_pulse: assert property (@(posedge clk) disable iff (!arst_n)
      reload |=> frame_boundary)
      else $error("boundary pulse missing after reload");
   a_boundary_quiet: assert property (@(posedge clk) disable iff (!arst_n)
      !reload |=> !frame_boundary)
      else $error("boundary pulse without reload");
   // a zero tick always marks a frame start for the neighbouring units
   a_zero_boundary: assert property (@(posedge clk) disable iff (!arst_n)
      s_zero_tick |=> frame_boundary)
      else $error("zero tick gave no boundary");
   a_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
      rdata_valid |-> rdata[15:14] == 2'b00)
      else $error("reserved bits not zero");
   a_interval_write: assert property (@(posedge clk) disable iff (!arst_n)
      wr_interval && !controller_soft_reset |=> interval_q == $past(interval_wmask))
      else $error("interval write lost");

   // ------------------------------------------------------------
   // read path and hold checks
   // ------------------------------------------------------------
   // a read answers on the very next edge with the value that stood when the
   // command was taken; a later counter step must not leak into the answer
   sequence s_interval_read;
      rd_interval;
   endsequence
   sequence s_remaining_read;
      rd_remaining;
   endsequence
   a_interval_answer: assert property (@(posedge clk) disable iff (!arst_n)
      s_interval_read |=> rdata_valid && rdata == $past(interval_q))
      else $error("interval read answer wrong");
   a_remaining_answer: assert property (@(posedge clk) disable iff (!arst_n)
      s_remaining_read |=> rdata_valid && rdata == $past(remain_view))
      else $error("remaining read answer wrong");
   // unknown codes and writes get no answer at all
   a_no_stray_answer: assert property (@(posedge clk) disable iff (!arst_n)
      !rd_interval && !rd_remaining |=> !rdata_valid && rdata == 32'h00000000)
      else $error("answer without a read");
   // reserved interval bits never hold a one, whatever software wrote
   a_reserved_store: assert property (@(posedge clk) disable iff (!arst_n)
      interval_q[15:14] == 2'b00)
      else $error("reserved interval bits set");
   // the interval register only moves on a write or a soft reset
   a_interval_hold: assert property (@(posedge clk) disable iff (!arst_n)
      !wr_interval && !controller_soft_reset |=> $stable(interval_q))
      else $error("interval changed without cause");
   // soft reset touches only the interval field, the toggle and budget survive
   a_soft_upper: assert property (@(posedge clk) disable iff (!arst_n)
      controller_soft_reset && !wr_interval |=>
      interval_q[31:FI_W] == $past(interval_q[31:FI_W]))
      else $error("soft reset disturbed upper bits");
   // the remaining toggle only changes when the counter passes zero
   a_toggle_hold: assert property (@(posedge clk) disable iff (!arst_n)
      !(tick && at_zero) |=> $stable(remain_toggle_q))
      else $error("remaining toggle moved off zero");
   // the budget counter is only loaded at a frame start
   a_budget_hold: assert property (@(posedge clk) disable iff (!arst_n)
      !reload |=> $stable(packet_count))
      else $error("budget changed mid frame");
   // bit rate is above clk, so the tick must stand on every edge out of reset
   a_tick_steady: assert property (@(posedge clk) disable iff (!arst_n)
      1'b1 |=> bit_tick)
      else $error("bit tick dropped");
endmodule // usb_host_frame_timer
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the usb host frame timer
`default_nettype none
module testbench
   import frame_timer_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, arst_n = 0, cmd_valid = 0, controller_soft_reset = 0, operational_state = 0;
   logic [7:0] cmd_code = 8'h00;
   logic [31:0] cmd_wdata = 32'h0, rdata;
   logic rdata_valid, frame_boundary, bit_tick;
   logic [BUDGET_W-1:0] packet_count;
   int fail_count = 0, compares = 0, n;
   logic [31:0] saved;
   typedef struct {logic [7:0] code; logic [31:0] wd; logic vld; logic [31:0] exp;} row_t;
   // last write leaves a short frame so the counter can be timed quickly
   row_t rows [6] = '{'{8'h8d, 32'h7fffffff, 1'b0, 32'h0}, '{8'h0d, 32'h0, 1'b1, 32'h7fff3fff},
      '{8'h0f, 32'h0, 1'b0, 32'h0}, '{8'h8e, 32'h1, 1'b0, 32'h0},
      '{8'h8d, 32'h92340004, 1'b0, 32'h0}, '{8'h0d, 32'h0, 1'b1, 32'h92340004}};
   usb_host_frame_timer u_usb_host_frame_timer (.clk(clk), .arst_n(arst_n),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
      .controller_soft_reset(controller_soft_reset), .operational_state(operational_state),
      .rdata(rdata), .rdata_valid(rdata_valid), .frame_boundary(frame_boundary),
      .bit_tick(bit_tick), .packet_count(packet_count));
   // ----------------------------------------
   // clock, tasks and watchdog
   // ----------------------------------------
   initial begin
      forever #50 clk = ~clk;
   end
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one-cycle strobe; the answer is registered, so it is read just after the taking edge
   task automatic cmd(logic [7:0] code, logic [31:0] wd);
      cmd_valid = 1;
      cmd_code = code;
      cmd_wdata = wd;
      @(posedge clk) #1;
      cmd_valid = 0;
   endtask
   task automatic wait_fb(int lim);
      n = 0;
      while (frame_boundary !== 1'b1 && n < lim) begin
         @(posedge clk) #1;
         n++;
      end
   endtask
   task automatic summarize();
      if (fail_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // the nominal first frame alone is 12000 cycles, so allow a few times the whole run
   initial begin
      repeat (40000) @(posedge clk);
      fail_count++;
      summarize();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      #300;
      check("reset rdata", 32'h0, rdata);
      check("reset budget", 32'h0, {17'h0, packet_count});
      repeat (6) @(posedge clk);
      #1 arst_n = 1;
      cmd(8'h0d, 32'h0);
      check("nominal interval", INTERVAL_RESET, rdata);
      foreach (rows[i]) begin
         cmd(rows[i].code, rows[i].wd);
         check("valid", {31'h0, rows[i].vld}, {31'h0, rdata_valid});
         check("data", rows[i].exp, rdata);
      end
      // new interval only takes hold once the running nominal frame ends
      wait_fb(20000);
      check("boundary seen", 32'h1, {31'h0, frame_boundary});
      check("budget", 32'h1234, {17'h0, packet_count});
      @(posedge clk) #1;
      wait_fb(20);
      check("frame period", 32'd4, n);
      check("bit tick", 32'h1, {31'h0, bit_tick});
      // trim the interval right at the frame start, inverting the toggle with it
      cmd(8'h8d, 32'h12340005);
      cmd(8'h0e, 32'h0);
      check("remaining toggle", 32'h1, {31'h0, rdata[31]});
      check("remaining reserved", 32'h0, {15'h0, rdata[30:14]});
      check("remaining range", 32'h1, {31'h0, rdata[13:0] <= 14'h4});
      // software saves the interval before the soft reset
      cmd(8'h0d, 32'h0);
      saved = rdata;
      check("trimmed interval", 32'h12340005, rdata);
      controller_soft_reset = 1;
      @(posedge clk) #1;
      controller_soft_reset = 0;
      cmd(8'h0d, 32'h0);
      check("soft reset interval", 32'h12342edf, rdata);
      // entering the operational state restarts the frame at once
      operational_state = 1;
      @(posedge clk) #1;
      check("operational boundary", 32'h1, {31'h0, frame_boundary});
      cmd(8'h0e, 32'h0);
      check("operational reload", {18'h0, FI_NOMINAL}, {18'h0, rdata[13:0]});
      cmd(8'h8d, saved ^ 32'h80000000);
      cmd(8'h0d, 32'h0);
      check("restored interval", 32'h92340005, rdata);
      summarize();
   end
endmodule // testbench
`default_nettype wire
